// [inc/pmcl_pkg.sv]
// Shared constants and carrier types for the port carrier, collision and latency block.
// Notes on behaviour
// - In both 100 Mb/s media modes carrier sense rises at most 20 bit times after the start of a received J.
// - Where a collision applies, the collision output rises at most 20 bit times after the start of a received J.
// - Carrier sense falls 13 to 28 bit times after a received T starts on twisted pair, and at most 26 on fiber.
// - The collision output falls 13 to 28 bit times after a received T starts on twisted pair, and at most 26 on fiber.
// - Receive data valid follows the rise of carrier sense by about 8 bit times.
// - At 100 Mb/s, transmit enable sampled high on a transmit clock edge raises carrier sense within 4 bit times.
// - At 100 Mb/s, transmit enable sampled low drops carrier sense within 16 bit times unless receive is still active.
// - On twisted pair the first transmitted symbol leaves 6 to 14 bit times after transmit enable is sampled high.
// - On fiber the first transmitted symbol leaves 6 to 14 bit times after transmit enable is sampled high.
// - In 10BASE-T mode link loss is declared once no link pulse has arrived for 50 to 150 ms.

package pmcl_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int BIT_NS = 10;
  localparam int BITS_PER_MII_CLK = 4;
  localparam int CLK_NS = 8;
  // Cycles lost between a start strobe and the registered output.
  // A timer loaded with n ends at edge n; the carrier and status flops add two more edges.
  localparam int PIPE_CYC = 2;

  // ----------------------------------------------------------------
  // Receive timing
  // ----------------------------------------------------------------
  localparam int J_CRS_MAX_BT = 20;
  localparam int J_CRS_BT = 16;
  localparam int J_CRS_CYC = (J_CRS_BT * BIT_NS) / CLK_NS;
  localparam int J_CRS_MAX_CYC = (J_CRS_MAX_BT * BIT_NS) / CLK_NS;
  localparam int T_MIN_BT = 13;
  localparam int T_MIN_CYC = (T_MIN_BT * BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_TP_MAX_BT = 28;
  localparam int T_FX_MAX_BT = 26;
  localparam int T_TP_BT = 22;
  localparam int T_FX_BT = 20;
  localparam int T_TP_CYC = (T_TP_BT * BIT_NS) / CLK_NS;
  localparam int T_FX_CYC = (T_FX_BT * BIT_NS) / CLK_NS;
  localparam int DV_BT = 8;
  localparam int DV_CYC = (DV_BT * BIT_NS) / CLK_NS;

  // ----------------------------------------------------------------
  // Transmit timing
  // ----------------------------------------------------------------
  localparam int TX_CRS_MAX_BT = 4;
  localparam int TX_DROP_MAX_BT = 16;
  localparam int TX_LAT_MIN_BT = 6;
  localparam int TX_LAT_MAX_BT = 14;
  localparam int TX_LAT_BT = 9;
  localparam int TX_LAT_CYC = (TX_LAT_BT * BIT_NS) / CLK_NS;

  // ----------------------------------------------------------------
  // Link integrity
  // ----------------------------------------------------------------
  localparam int LINK_LOSS_MIN_MS = 50;
  localparam int LINK_LOSS_MAX_MS = 150;
  localparam int LINK_LOSS_MS = 100;
  localparam int LINK_LOSS_CYC = (LINK_LOSS_MS * 1000000) / CLK_NS;
  localparam int LINK_CNT_W = 24;
  localparam int DLY_W = 6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic crs;
    logic col;
    logic rx_dv;
  } pmcl_mii_stat_t;

  typedef struct packed {
    logic fiber;
    logic ten;
    logic half_duplex;
  } pmcl_mode_t;

endpackage

// [verilog/pmcl_delay.sv]
// One-shot delay timer that pulses done a loaded number of cycles after start.
`timescale 1ns/10ps

module pmcl_delay #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] load,
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  wire expire = busy_reg && (cnt_reg == W'(1));

  // A fresh start restarts the count, so a new delimiter always wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= expire && !start && !cancel;
      if (start) begin
        cnt_reg <= load;
        busy_reg <= (load != '0);
      end else if (cancel || expire) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign done = done_reg;

endmodule

// [verilog/pmcl_port.sv]
// Per-port carrier sense, collision, receive valid, transmit latency and link loss logic.
`timescale 1ns/10ps

module pmcl_port #(
  parameter int LINK_LOSS_CYC = pmcl_pkg::LINK_LOSS_CYC,
  parameter int LINK_CNT_W = pmcl_pkg::LINK_CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire pmcl_pkg::pmcl_mode_t mode,
  input wire logic rx_j_start,
  input wire logic rx_t_start,
  input wire logic mii_tx_clk,
  input wire logic mii_tx_en,
  input wire logic link_pulse,
  output pmcl_pkg::pmcl_mii_stat_t mii_stat,
  output logic twisted_pair_out_pos,
  output logic fiber_out_pos,
  output logic link_loss
);

  localparam int DW = pmcl_pkg::DLY_W;
  localparam int TXL = pmcl_pkg::TX_LAT_CYC;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tx_clk_s1_reg, tx_clk_s2_reg, tx_clk_s3_reg;
  logic tx_en_s1_reg, tx_en_s2_reg;
  logic lp_s1_reg, lp_s2_reg, lp_s3_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_clk_s1_reg <= 1'b0;
      tx_clk_s2_reg <= 1'b0;
      tx_clk_s3_reg <= 1'b0;
      tx_en_s1_reg <= 1'b0;
      tx_en_s2_reg <= 1'b0;
      lp_s1_reg <= 1'b0;
      lp_s2_reg <= 1'b0;
      lp_s3_reg <= 1'b0;
    end else begin
      tx_clk_s1_reg <= mii_tx_clk;
      tx_clk_s2_reg <= tx_clk_s1_reg;
      tx_clk_s3_reg <= tx_clk_s2_reg;
      tx_en_s1_reg <= mii_tx_en;
      tx_en_s2_reg <= tx_en_s1_reg;
      lp_s1_reg <= link_pulse;
      lp_s2_reg <= lp_s1_reg;
      lp_s3_reg <= lp_s2_reg;
    end
  end

  // Both pins pass the same two stages, so the enable stays aligned with its clock edge.
  wire tx_sample = tx_clk_s2_reg && !tx_clk_s3_reg;
  wire lp_rise = lp_s2_reg && !lp_s3_reg;
  wire fast_mode = !mode.ten;

  // ----------------------------------------------------------------
  // Transmit activity
  // ----------------------------------------------------------------
  logic tx_act_reg;
  wire tx_act_next = tx_sample ? tx_en_s2_reg : tx_act_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_act_reg <= 1'b0;
    end else begin
      tx_act_reg <= tx_act_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive carrier timers
  // ----------------------------------------------------------------
  logic rx_carrier_reg;
  logic j_done, t_done, dv_done;
  wire j_go = rx_j_start && fast_mode;
  wire t_go = rx_t_start && fast_mode && rx_carrier_reg;
  wire [DW-1:0] j_load = DW'(pmcl_pkg::J_CRS_CYC - pmcl_pkg::PIPE_CYC);
  wire [DW-1:0] t_load_tp = DW'(pmcl_pkg::T_TP_CYC - pmcl_pkg::PIPE_CYC);
  wire [DW-1:0] t_load_fx = DW'(pmcl_pkg::T_FX_CYC - pmcl_pkg::PIPE_CYC);
  wire [DW-1:0] t_load = mode.fiber ? t_load_fx : t_load_tp;
  wire [DW-1:0] dv_load = DW'(pmcl_pkg::DV_CYC);

  pmcl_delay #(.W(DW)) u_j_timer (
    .clk(clk),
    .srst(srst),
    .start(j_go),
    .cancel(mode.ten),
    .load(j_load),
    .done(j_done)
  );

  pmcl_delay #(.W(DW)) u_t_timer (
    .clk(clk),
    .srst(srst),
    .start(t_go),
    .cancel(j_go),
    .load(t_load),
    .done(t_done)
  );

  pmcl_delay #(.W(DW)) u_dv_timer (
    .clk(clk),
    .srst(srst),
    .start(j_done),
    .cancel(t_done),
    .load(dv_load),
    .done(dv_done)
  );

  // A stale end timer must not cut a new stream, so a J cancels it above.
  wire rx_carrier_next = fast_mode && (j_done || (rx_carrier_reg && !t_done));

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_carrier_reg <= 1'b0;
    end else begin
      rx_carrier_reg <= rx_carrier_next;
    end
  end

  // ----------------------------------------------------------------
  // MII status outputs
  // ----------------------------------------------------------------
  pmcl_pkg::pmcl_mii_stat_t stat_reg;
  pmcl_pkg::pmcl_mii_stat_t stat_next;
  wire crs_next = rx_carrier_reg || tx_act_reg;
  wire col_next = mode.half_duplex && rx_carrier_reg && tx_act_reg;
  wire dv_next = rx_carrier_reg && (dv_done || stat_reg.rx_dv);

  assign stat_next.crs = crs_next;
  assign stat_next.col = col_next;
  assign stat_next.rx_dv = dv_next;

  always_ff @(posedge clk) begin
    if (srst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign mii_stat = stat_reg;

  // ----------------------------------------------------------------
  // Transmit latency to the line
  // ----------------------------------------------------------------
  // The line path is a plain delay line; the output flop supplies the last stage.
  logic [TXL-2:0] tx_line_reg;
  logic tp_out_reg, fx_out_reg;
  wire line_on = tx_line_reg[TXL-2];

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_line_reg <= '0;
      tp_out_reg <= 1'b0;
      fx_out_reg <= 1'b0;
    end else begin
      tx_line_reg <= {tx_line_reg[TXL-3:0], tx_act_reg};
      tp_out_reg <= line_on && fast_mode && !mode.fiber;
      fx_out_reg <= line_on && fast_mode && mode.fiber;
    end
  end

  assign twisted_pair_out_pos = tp_out_reg;
  assign fiber_out_pos = fx_out_reg;

  // ----------------------------------------------------------------
  // 10BASE-T link integrity
  // ----------------------------------------------------------------
  // The count is wide and slow; shorten LINK_LOSS_CYC for simulation.
  logic [LINK_CNT_W-1:0] link_cnt_reg;
  logic link_loss_reg;
  wire link_timeout = (link_cnt_reg == LINK_CNT_W'(LINK_LOSS_CYC - 1));

  always_ff @(posedge clk) begin
    if (srst || !mode.ten || lp_rise) begin
      link_cnt_reg <= '0;
      link_loss_reg <= 1'b0;
    end else if (link_timeout) begin
      link_loss_reg <= 1'b1;
    end else begin
      link_cnt_reg <= link_cnt_reg + LINK_CNT_W'(1);
    end
  end

  assign link_loss = link_loss_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_crs_after_j;
    @(posedge clk) disable iff (srst)
      (j_go && !mode.ten) ##1 (!mode.ten && !rx_t_start)[*8] |-> ##[1:17] stat_reg.crs;
  endproperty
  a_crs_after_j: assert property (p_crs_after_j) else $error("carrier late after J");

  property p_col_after_j;
    @(posedge clk) disable iff (srst)
      (j_go && mode.half_duplex && tx_act_reg) |->
        ##[1:25] (stat_reg.col || !tx_act_reg || !mode.half_duplex || rx_t_start);
  endproperty
  a_col_after_j: assert property (p_col_after_j) else $error("collision late after J");

  sequence s_tp_end_held;
    (t_go && !mode.fiber && !tx_act_reg) ##16 rx_carrier_reg;
  endsequence
  property p_crs_end_tp;
    @(posedge clk) disable iff (srst)
      s_tp_end_held |-> ##[1:19] !stat_reg.crs || rx_j_start || tx_act_reg;
  endproperty
  a_crs_end_tp: assert property (p_crs_end_tp) else $error("carrier end out of window");

  property p_crs_end_min;
    @(posedge clk) disable iff (srst)
      (t_go && !tx_act_reg) ##1 (!rx_j_start && !mode.ten)[*8] |-> stat_reg.crs;
  endproperty
  a_crs_end_min: assert property (p_crs_end_min) else $error("carrier dropped early");

  property p_col_end_fx;
    @(posedge clk) disable iff (srst)
      (t_go && mode.fiber) |-> ##[1:32] (!stat_reg.col || rx_j_start);
  endproperty
  a_col_end_fx: assert property (p_col_end_fx) else $error("collision held past fiber end");

  property p_dv_follows_crs;
    @(posedge clk) disable iff (srst)
      j_done ##2 (rx_carrier_reg)[*8] ##1 rx_carrier_reg[*3] |-> stat_reg.rx_dv;
  endproperty
  a_dv_follows_crs: assert property (p_dv_follows_crs) else $error("rx valid not 8 BT after carrier");

  property p_tx_crs_on;
    @(posedge clk) disable iff (srst)
      (tx_sample && tx_en_s2_reg) |-> ##2 stat_reg.crs;
  endproperty
  a_tx_crs_on: assert property (p_tx_crs_on) else $error("carrier late after TX enable");

  property p_tx_crs_off;
    @(posedge clk) disable iff (srst)
      (tx_sample && !tx_en_s2_reg && !rx_carrier_reg && !rx_carrier_next) |->
        ##2 (!stat_reg.crs || rx_carrier_reg);
  endproperty
  a_tx_crs_off: assert property (p_tx_crs_off) else $error("carrier held after TX enable off");

  property p_tp_latency;
    @(posedge clk) disable iff (srst)
      ($rose(tx_act_reg) && !mode.fiber && !mode.ten) ##1 (!mode.fiber && !mode.ten)[*8]
        |-> ##3 twisted_pair_out_pos;
  endproperty
  a_tp_latency: assert property (p_tp_latency) else $error("twisted pair latency wrong");

  property p_fx_latency;
    @(posedge clk) disable iff (srst)
      $rose(fiber_out_pos) |-> $past(tx_act_reg, 11) && !$past(tx_act_reg, 12);
  endproperty
  a_fx_latency: assert property (p_fx_latency) else $error("fiber latency wrong");

  property p_link_loss_clear;
    @(posedge clk) disable iff (srst)
      (lp_rise || !mode.ten) |=> !link_loss && (link_cnt_reg == '0);
  endproperty
  a_link_loss_clear: assert property (p_link_loss_clear) else $error("link loss not cleared");

  property p_col_overlap;
    @(posedge clk) disable iff (srst)
      stat_reg.col |-> $past(mode.half_duplex) && $past(rx_carrier_reg) && $past(tx_act_reg);
  endproperty
  a_col_overlap: assert property (p_col_overlap) else $error("collision without overlap");

endmodule

// [verification/pmcl_mac_model.sv]
// Behavioural MAC transmit side that clocks frames onto the MII transmit pins.
`timescale 1ns/10ps

module pmcl_mac_model #(
  parameter int HALF_NS = 32
) (
  output logic tx_clk,
  output logic tx_en
);
  time t_on;

  initial begin
    tx_clk = 1'b0;
    tx_en = 1'b0;
    t_on = 0;
  end

  // ----------------------------------------------------------------
  // Frame transmission
  // ----------------------------------------------------------------
  // The clock stands low between frames, so each frame starts with a clean edge to time from.
  // Transmit enable changes only while the clock is low, a half period ahead of its sampling edge.
  task automatic send_frame(input int nibbles);
    tx_en = 1'b1;
    #(HALF_NS) tx_clk = 1'b1;
    t_on = $time;
    repeat (nibbles) begin
      #(HALF_NS) tx_clk = 1'b0;
      #(HALF_NS) tx_clk = 1'b1;
    end
    #(HALF_NS) tx_clk = 1'b0;
    tx_en = 1'b0;
    #(HALF_NS) tx_clk = 1'b1;
    #(HALF_NS) tx_clk = 1'b0;
  endtask
endmodule

// [verification/tb_pmcl_port.sv]
// Self-checking bench for the port carrier, collision and latency block.
`timescale 1ns/10ps

module tb_pmcl_port;
  localparam int LOSS = 200;
  localparam int CK = pmcl_pkg::CLK_NS;
  logic clk;
  logic srst;
  pmcl_pkg::pmcl_mode_t mode;
  logic rx_j_start;
  logic rx_t_start;
  logic mii_tx_clk;
  logic mii_tx_en;
  logic link_pulse;
  pmcl_pkg::pmcl_mii_stat_t mii_stat;
  logic twisted_pair_out_pos;
  logic fiber_out_pos;
  logic link_loss;
  logic [5:0] obs;
  logic line_seen;
  int num_errors;
  int samples_checked;
  time t0;

  // Bits: 0 rx_dv, 1 col, 2 crs, 3 twisted pair, 4 fiber, 5 link loss.
  assign obs = {link_loss, fiber_out_pos, twisted_pair_out_pos, mii_stat};

  pmcl_port #(.LINK_LOSS_CYC(LOSS), .LINK_CNT_W(pmcl_pkg::LINK_CNT_W)) i_dut (
    .clk(clk), .srst(srst), .mode(mode), .rx_j_start(rx_j_start),
    .rx_t_start(rx_t_start), .mii_tx_clk(mii_tx_clk), .mii_tx_en(mii_tx_en),
    .link_pulse(link_pulse), .mii_stat(mii_stat),
    .twisted_pair_out_pos(twisted_pair_out_pos), .fiber_out_pos(fiber_out_pos),
    .link_loss(link_loss));

  pmcl_mac_model i_mac (.tx_clk(mii_tx_clk), .tx_en(mii_tx_en));

  initial begin
    clk = 1'b0;
    forever #(CK / 2) clk = ~clk;
  end

  // Catches a line output that lights up in a mode where it must stay dark.
  always @(posedge clk) begin
    if ((twisted_pair_out_pos === 1'b1 && (mode.fiber || mode.ten)) ||
        (fiber_out_pos === 1'b1 && (!mode.fiber || mode.ten))) begin
      line_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_span(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Returns the nanoseconds from t0 to the clock edge where the output took its level.
  task automatic wait_for(input int idx, input logic lvl, input int max_cyc, output int ns);
    int k;
    k = 0;
    while (obs[idx] !== lvl) begin
      if (k == max_cyc) begin
        num_errors++;
        $display("CHECK FAILED output %0d expected %b seen %b", idx, lvl, obs[idx]);
        end_sim();
      end
      @(posedge clk);
      #1;
      k++;
    end
    ns = int'($time - t0) - 1;
  endtask

  task automatic strobe(input logic t_code);
    @(posedge clk);
    #1;
    rx_j_start = !t_code;
    rx_t_start = t_code;
    @(posedge clk);
    t0 = $time;
    #1;
    rx_j_start = 1'b0;
    rx_t_start = 1'b0;
  endtask

  // Waits for a MAC clock rise, or a transmit enable fall, with a bounded guard.
  task automatic wait_mac(input logic en_fall);
    fork
      begin
        fork
          if (en_fall) begin
            @(negedge mii_tx_en);
          end else begin
            @(posedge mii_tx_clk);
          end
          begin
            repeat (300) @(posedge clk);
            num_errors++;
            $display("CHECK FAILED mac pin edge expected edge seen none");
            end_sim();
          end
        join_any
        disable fork;
      end
    join
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_receive(input logic fiber);
    int ns;
    mode = '{fiber: fiber, ten: 1'b0, half_duplex: 1'b1};
    strobe(1'b0);
    wait_for(2, 1'b1, 40, ns);
    chk_span("crs after J", pmcl_pkg::J_CRS_CYC, pmcl_pkg::J_CRS_CYC, ns / CK);
    chk_bit("col with no transmit", 1'b0, mii_stat.col);
    t0 = $time - 1;
    wait_for(0, 1'b1, 20, ns);
    chk_span("rx_dv after crs", pmcl_pkg::DV_CYC, pmcl_pkg::DV_CYC, ns / CK);
    strobe(1'b1);
    wait_for(2, 1'b0, 45, ns);
    chk_span("crs after T", fiber ? pmcl_pkg::T_FX_CYC : pmcl_pkg::T_TP_CYC,
             fiber ? pmcl_pkg::T_FX_CYC : pmcl_pkg::T_TP_CYC, ns / CK);
    chk_bit("rx_dv after T", 1'b0, mii_stat.rx_dv);
    repeat (30) @(posedge clk);
    #1;
  endtask

  task automatic sc_transmit(input logic fiber, input logic ten);
    int ns;
    mode = '{fiber: fiber, ten: ten, half_duplex: 1'b0};
    line_seen = 1'b0;
    fork
      i_mac.send_frame(8);
    join_none
    wait_mac(1'b0);
    t0 = $time;
    @(posedge clk);
    #1;
    if (!ten) begin
      wait_for(2, 1'b1, 10, ns);
      chk_span("crs after transmit enable", 0, 40 + CK, ns);
      wait_for(fiber ? 4 : 3, 1'b1, 25, ns);
      chk_span("line output latency", 60, 140 + CK, ns);
    end
    wait_mac(1'b1);
    wait_mac(1'b0);
    t0 = $time;
    @(posedge clk);
    #1;
    if (!ten) begin
      wait_for(2, 1'b0, 25, ns);
      chk_span("crs after transmit end", 0, 160 + CK, ns);
    end
    repeat (30) @(posedge clk);
    #1;
    chk_bit("wrong line output", 1'b0, line_seen);
  endtask

  task automatic sc_collision(input logic half);
    int ns;
    mode = '{fiber: 1'b0, ten: 1'b0, half_duplex: half};
    fork
      i_mac.send_frame(12);
    join_none
    repeat (12) @(posedge clk);
    strobe(1'b0);
    if (half) begin
      wait_for(1, 1'b1, 40, ns);
      chk_span("col after J", pmcl_pkg::J_CRS_CYC, pmcl_pkg::J_CRS_CYC, ns / CK);
      strobe(1'b1);
      wait_for(1, 1'b0, 45, ns);
      chk_span("col after T", pmcl_pkg::T_TP_CYC, pmcl_pkg::T_TP_CYC, ns / CK);
    end else begin
      repeat (30) @(posedge clk);
      #1;
      chk_bit("col in full duplex", 1'b0, mii_stat.col);
      strobe(1'b1);
    end
    wait_mac(1'b1);
    repeat (40) @(posedge clk);
    #1;
    chk_bit("crs after frame", 1'b0, mii_stat.crs);
    chk_bit("col after frame", 1'b0, mii_stat.col);
  endtask

  task automatic sc_link();
    int ns;
    mode = '{fiber: 1'b0, ten: 1'b1, half_duplex: 1'b0};
    strobe(1'b0);
    repeat (3) begin
      repeat (LOSS / 2) @(posedge clk);
      #1;
      link_pulse = 1'b1;
      t0 = $time - 1;
      repeat (4) @(posedge clk);
      #1;
      link_pulse = 1'b0;
    end
    chk_bit("crs from J in 10 Mb/s", 1'b0, mii_stat.crs);
    chk_bit("loss while pulses arrive", 1'b0, link_loss);
    wait_for(5, 1'b1, LOSS + 20, ns);
    chk_span("link loss delay", LOSS, LOSS + 6, ns / CK);
    link_pulse = 1'b1;
    t0 = $time - 1;
    wait_for(5, 1'b0, 10, ns);
    chk_span("link loss clear", 1, 8, ns / CK);
    link_pulse = 1'b0;
  endtask

  initial begin
    srst = 1'b1;
    mode = '0;
    rx_j_start = 1'b0;
    rx_t_start = 1'b0;
    link_pulse = 1'b0;
    line_seen = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    t0 = 0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    sc_receive(1'b0);
    sc_receive(1'b1);
    sc_transmit(1'b0, 1'b0);
    sc_transmit(1'b1, 1'b0);
    sc_collision(1'b1);
    sc_collision(1'b0);
    sc_link();
    sc_transmit(1'b0, 1'b1);
    end_sim();
  end
endmodule
